// ---- common/ebs_pkg.sv ----
package ebs_pkg;

  // ---------------------------------------------------------------
  // transfer size codes on the size outputs
  // ---------------------------------------------------------------
  localparam logic [1:0] SIZE_LONG  = 2'h0;
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  // ---------------------------------------------------------------
  // acknowledge decode, {hi_n, lo_n}
  // ---------------------------------------------------------------
  localparam logic [1:0] ACK_WAIT  = 2'h3;
  localparam logic [1:0] ACK_PORT8 = 2'h2;
  localparam logic [1:0] ACK_PORT16 = 2'h1;
  localparam logic [1:0] ACK_RSVD  = 2'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int BUS_MONITOR_NS    = 640;
  localparam int BUS_MONITOR_CYC   = BUS_MONITOR_NS / CLK_PERIOD_NS;
  localparam logic [7:0] MON_RESET = 8'h00;
  localparam int ADDR_W            = 24;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic        int_ack;
    logic [1:0]  size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } op_req_t;

  typedef struct packed {
    logic        done;
    logic        fault;
    logic        misaligned;
    logic        auto_vec;
    logic        fault_halt;
    logic [31:0] rdata;
  } op_resp_t;

  typedef struct packed {
    logic [1:0] ack_n;
    logic       fault_n;
    logic       halt_n;
    logic       auto_vector_req_n_n;
  } term_pins_t;

  typedef enum logic [2:0] {
    TERM_NONE,
    TERM_PORT8,
    TERM_PORT16,
    TERM_FAULT,
    TERM_AUTO_VECTOR_REQ_N
  } term_t;

endpackage : ebs_pkg

// ---- hw/term_decode.sv ----
// ---------------------------------------------------------------
// cycle termination decoder, pure logic on synchronised pins
// ---------------------------------------------------------------
module term_decode (
  input  wire logic               int_ack,
  input  wire logic               monitor_fault,
  input  wire ebs_pkg::term_pins_t pins,
  output      ebs_pkg::term_t      term,
  output      logic                halt_too
);
  always_comb begin
    term     = ebs_pkg::TERM_NONE;
    halt_too = 1'b0;
    // fault wins over any acknowledge seen with it
    if (!pins.fault_n || monitor_fault) begin
      term     = ebs_pkg::TERM_FAULT;
      halt_too = !pins.halt_n;
    end else if (int_ack && !pins.auto_vector_req_n_n) begin
      term = ebs_pkg::TERM_AUTO_VECTOR_REQ_N;
    end else begin
      case (pins.ack_n)
        ebs_pkg::ACK_PORT8:  term = ebs_pkg::TERM_PORT8;
        ebs_pkg::ACK_PORT16: term = ebs_pkg::TERM_PORT16;
        // reserved code treated as wait: never ends a cycle
        default:             term = ebs_pkg::TERM_NONE;
      endcase
    end
  end
endmodule : term_decode

// ---- hw/ext_bus_sizer.sv ----
module ext_bus_sizer (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // operand request side, same clock domain
  input  wire logic              op_valid,
  input  wire ebs_pkg::op_req_t  op_req,
  output      logic              op_ready,
  output      ebs_pkg::op_resp_t op_resp,
  // external bus pins
  output      logic [23:0]       addr_out,
  output      logic              xfer_size_hi,
  output      logic              xfer_size_lo,
  output      logic              addr_strobe_n,
  output      logic              rd_wr_n,
  output      logic [15:0]       data_out,
  output      logic              data_oe,
  input  wire logic [15:0]       data_in,
  input  wire logic              port_ack_hi_n,
  input  wire logic              port_ack_lo_n,
  input  wire logic              bus_fault_n,
  input  wire logic              halt_n,
  input  wire logic              auto_vector_req_n
);

  // ---------------------------------------------------------------
  // types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CYCLE,
    ST_GAP
  } state_t;

  // byte k of the operand, counted from the most significant
  function automatic logic [7:0] op_byte(input logic [31:0] v,
                                         input logic [2:0]  k);
    logic [7:0] b;
    b = 8'h00;
    case (k)
      3'h0:    b = v[31:24];
      3'h1:    b = v[23:16];
      3'h2:    b = v[15:8];
      3'h3:    b = v[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : op_byte

  // operand length in bytes for a size code
  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    logic [2:0] n;
    n = 3'h4;
    case (s)
      ebs_pkg::SIZE_BYTE:  n = 3'h1;
      ebs_pkg::SIZE_WORD:  n = 3'h2;
      ebs_pkg::SIZE_THREE: n = 3'h3;
      default:             n = 3'h4;
    endcase
    return n;
  endfunction : size_bytes

  // byte k of v replaced by b, k counted from the most significant
  function automatic logic [31:0] put_byte(input logic [31:0] v,
                                           input logic [2:0]  k,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = v;
    case (k)
      3'h0:    r[31:24] = b;
      3'h1:    r[23:16] = b;
      3'h2:    r[15:8]  = b;
      3'h3:    r[7:0]   = b;
      default: r = v;
    endcase
    return r;
  endfunction : put_byte

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0]  pins_s1_q;
  logic [4:0]  pins_s2_q;
  logic [15:0] din_s1_q;
  logic [15:0] din_s2_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pins_s1_q <= 5'h1f;
      pins_s2_q <= 5'h1f;
    end else begin
      pins_s1_q <= {port_ack_hi_n, port_ack_lo_n, bus_fault_n, halt_n,
                    auto_vector_req_n};
      pins_s2_q <= pins_s1_q;
    end
  end

  // data sampled one stage later than nothing: both paths are two deep
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  ebs_pkg::term_pins_t pins;
  assign pins = ebs_pkg::term_pins_t'(pins_s2_q);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t       state_q;
  logic [23:0]  addr_q;
  logic [2:0]   left_q;
  logic [2:0]   idx_q;
  logic         write_q;
  logic         int_ack_q;
  logic [31:0]  wdata_q;
  logic [31:0]  rdata_q;
  logic [7:0]   mon_q;
  logic         monitor_fault;
  ebs_pkg::term_t term;
  logic         halt_too;
  logic [2:0]   len_q;
  logic [31:0]  rdata_next;
  logic [31:0]  rd_final;
  logic         take;
  logic         misaligned;
  logic [2:0]   req_len;
  logic         is_port;
  logic         last;
  logic         ended;
  logic         gap_clear;
  logic         launch;

  term_decode u_term (
    .int_ack       (int_ack_q),
    .monitor_fault (monitor_fault),
    .pins          (pins),
    .term          (term),
    .halt_too      (halt_too)
  );

  // ---------------------------------------------------------------
  // current size code from remaining bytes
  // ---------------------------------------------------------------
  logic [1:0] size_now;
  always_comb begin
    case (left_q)
      3'h1:    size_now = ebs_pkg::SIZE_BYTE;
      3'h2:    size_now = ebs_pkg::SIZE_WORD;
      3'h3:    size_now = ebs_pkg::SIZE_THREE;
      default: size_now = ebs_pkg::SIZE_LONG;
    endcase
  end

  // ---------------------------------------------------------------
  // write lane steering
  // ---------------------------------------------------------------
  logic [7:0]  lead_byte;
  logic [7:0]  next_byte;
  logic [15:0] wlanes;
  always_comb begin
    lead_byte = op_byte(wdata_q, idx_q);
    next_byte = op_byte(wdata_q, 3'(idx_q + 3'h1));
    if (left_q == 3'h1 || addr_q[0]) begin
      // single byte copied to both lanes for either port
      wlanes = {lead_byte, lead_byte};
    end else begin
      // assumes a 16-bit port; an 8-bit port takes the upper lane
      wlanes = {lead_byte, next_byte};
    end
  end

  // ---------------------------------------------------------------
  // bytes accepted by the reported port
  // ---------------------------------------------------------------
  logic [2:0] moved;
  always_comb begin
    if (term == ebs_pkg::TERM_PORT16 && left_q != 3'h1 && !addr_q[0]) begin
      moved = 3'h2;
    end else begin
      moved = 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // bus monitor: faults cycles nobody terminates
  // ---------------------------------------------------------------
  // fixed window: a slower port must acknowledge sooner or it faults
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mon_q <= ebs_pkg::MON_RESET;
    end else if (state_q == ST_CYCLE && term == ebs_pkg::TERM_NONE) begin
      mon_q <= 8'(mon_q + 8'h01);
    end else begin
      mon_q <= ebs_pkg::MON_RESET;
    end
  end

  assign monitor_fault = (state_q == ST_CYCLE) &&
                         (mon_q == 8'(ebs_pkg::BUS_MONITOR_CYC - 1));

  // ---------------------------------------------------------------
  // request and termination decode
  // ---------------------------------------------------------------
  assign take       = op_valid && op_ready && (state_q == ST_IDLE);
  assign req_len    = size_bytes(op_req.size);
  // odd word or long is refused before any bus cycle runs
  assign misaligned = (op_req.size != ebs_pkg::SIZE_BYTE) &&
                      op_req.addr[0];
  assign is_port    = (term == ebs_pkg::TERM_PORT8) ||
                      (term == ebs_pkg::TERM_PORT16);
  assign ended      = (state_q == ST_CYCLE) && (term != ebs_pkg::TERM_NONE);
  assign last       = is_port && (left_q == moved);
  assign gap_clear  = (pins.ack_n == ebs_pkg::ACK_WAIT);
  assign launch     = (state_q == ST_GAP) && (left_q != 3'h0) && gap_clear;

  // ---------------------------------------------------------------
  // read lane selection
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_q;
    if (term == ebs_pkg::TERM_PORT16 && moved == 3'h2) begin
      rdata_next = put_byte(rdata_q, idx_q, din_s2_q[15:8]);
      rdata_next = put_byte(rdata_next, 3'(idx_q + 3'h1), din_s2_q[7:0]);
    end else if (term == ebs_pkg::TERM_PORT16 && addr_q[0]) begin
      rdata_next = put_byte(rdata_q, idx_q, din_s2_q[7:0]);
    end else if (is_port) begin
      // narrow port, or single even byte on a wide port: upper lane only, lower lane is not used
      rdata_next = put_byte(rdata_q, idx_q, din_s2_q[15:8]);
    end
  end

  assign rd_final = rdata_next >> {3'(3'h4 - len_q), 3'h0};

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  // a gap follows every cycle until the synchronised acknowledge is
  // gone, so a stale acknowledge never ends the next cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  state_q <= take ? ST_GAP : ST_IDLE;
        ST_CYCLE: state_q <= ended ? ST_GAP : ST_CYCLE;
        ST_GAP:   state_q <= !gap_clear ? ST_GAP :
                             (left_q == 3'h0) ? ST_IDLE : ST_CYCLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // operand progress
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_q    <= 24'h00_0000;
      left_q    <= 3'h0;
      idx_q     <= 3'h0;
      len_q     <= 3'h0;
      write_q   <= 1'b0;
      int_ack_q <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      rdata_q   <= 32'h0000_0000;
    end else if (take) begin
      addr_q    <= op_req.addr;
      left_q    <= misaligned ? 3'h0 : req_len;
      idx_q     <= 3'h0;
      len_q     <= req_len;
      write_q   <= op_req.write;
      int_ack_q <= op_req.int_ack;
      // operand moved to the top so byte 0 sits in bits 31..24
      wdata_q   <= op_req.wdata << {3'(3'h4 - req_len), 3'h0};
      rdata_q   <= 32'h0000_0000;
    end else if (ended && is_port) begin
      addr_q    <= 24'(addr_q + 24'(moved));
      left_q    <= 3'(left_q - moved);
      idx_q     <= 3'(idx_q + moved);
      if (!write_q) begin
        rdata_q <= rdata_next;
      end
    end else if (ended) begin
      // fault and autovector end the whole operand
      left_q    <= 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // bus pins
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_out      <= 24'h00_0000;
      xfer_size_hi  <= 1'b0;
      xfer_size_lo  <= 1'b0;
      addr_strobe_n <= 1'b1;
      rd_wr_n       <= 1'b1;
      data_out      <= 16'h0000;
      data_oe       <= 1'b0;
    end else if (launch) begin
      // size and address change only while the strobe is high
      addr_out      <= addr_q;
      xfer_size_hi  <= size_now[1];
      xfer_size_lo  <= size_now[0];
      addr_strobe_n <= 1'b0;
      rd_wr_n       <= !write_q;
      data_out      <= wlanes;
      data_oe       <= write_q;
    end else if (ended) begin
      addr_strobe_n <= 1'b1;
      data_oe       <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // operand handshake
  // ---------------------------------------------------------------
  // response is a one-cycle pulse; ready comes back only in idle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      op_ready <= 1'b0;
      op_resp  <= '0;
    end else begin
      op_ready <= (state_q == ST_IDLE) && !take;
      op_resp  <= '0;
      if (take && misaligned) begin
        op_resp.done       <= 1'b1;
        op_resp.misaligned <= 1'b1;
      end else if (ended && term == ebs_pkg::TERM_FAULT) begin
        op_resp.done       <= 1'b1;
        op_resp.fault      <= 1'b1;
        op_resp.fault_halt <= halt_too;
      end else if (ended && term == ebs_pkg::TERM_AUTO_VECTOR_REQ_N) begin
        // vector is made internally, bus data is not taken
        op_resp.done       <= 1'b1;
        op_resp.auto_vec   <= 1'b1;
      end else if (ended && last) begin
        op_resp.done       <= 1'b1;
        op_resp.rdata      <= write_q ? 32'h0000_0000 : rd_final;
      end
    end
  end

endmodule : ext_bus_sizer

// ---- verification/ext_bus_sizer_monitor.sv ----
module ext_bus_sizer_monitor (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire ebs_pkg::op_resp_t op_resp,
  input wire logic              xfer_size_hi,
  input wire logic              xfer_size_lo,
  input wire logic              addr_strobe_n,
  input wire logic              rd_wr_n,
  input wire logic [15:0]       data_out,
  input wire logic              data_oe,
  input wire logic              port_ack_hi_n,
  input wire logic              port_ack_lo_n,
  input wire logic              bus_fault_n,
  input wire logic              halt_n
);
  // ----------
  // bus cycle checks
  // ----------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [1:0] sz = {xfer_size_hi, xfer_size_lo};
  wire [1:0] ak = {port_ack_hi_n, port_ack_lo_n};
  wire       cyc = !addr_strobe_n;
  chk_size_hold: assert property (
    cyc && $past(cyc) |-> $stable(sz)) else $error("size moved");
  chk_write_oe: assert property (
    cyc && $past(cyc) && !rd_wr_n |-> data_oe) else $error("write oe");
  chk_byte_copy: assert property (
    cyc && data_oe && sz == 2'h1 |-> data_out[15:8] == data_out[7:0])
    else $error("byte lanes");
  chk_long_wide: assert property (
    cyc && sz == 2'h0 && ak == ebs_pkg::ACK_PORT16
    |-> ##[1:20] cyc && sz == 2'h2) else $error("long wide");
  chk_long_narrow: assert property (
    cyc && sz == 2'h0 && ak == ebs_pkg::ACK_PORT8
    |-> ##[1:20] cyc && sz == 2'h3) else $error("long narrow");
  chk_word_narrow: assert property (
    cyc && sz == 2'h2 && ak == ebs_pkg::ACK_PORT8
    |-> ##[1:20] cyc && sz == 2'h1) else $error("word narrow");
  chk_fault_end: assert property (
    cyc && !bus_fault_n |-> ##[0:6] op_resp.fault) else $error("fault");
  chk_fault_halt: assert property (
    cyc && !bus_fault_n && !halt_n |-> ##[0:6] op_resp.fault_halt)
    else $error("halt");
endmodule : ext_bus_sizer_monitor

bind ext_bus_sizer ext_bus_sizer_monitor u_ext_bus_sizer_monitor (.*);

// ---- verification/ext_port_model.sv ----
module ext_port_model (
  input  wire logic        sys_clk,
  input  wire logic        wide,
  input  wire logic        mute,
  input  wire logic [1:0]  lat,
  input  wire logic [23:0] addr_out,
  input  wire logic        xfer_size_hi,
  input  wire logic        xfer_size_lo,
  input  wire logic        addr_strobe_n,
  input  wire logic        rd_wr_n,
  input  wire logic [15:0] data_out,
  output      logic [15:0] data_in,
  output      logic        port_ack_hi_n,
  output      logic        port_ack_lo_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // port with 8 or 16 bit width
  // ----------
  logic [7:0] mem_q [16];
  logic [1:0] cnt_q;
  wire  [3:0] a = addr_out[3:0];
  wire  [3:0] e = {a[3:1], 1'h0};
  wire  [3:0] o = {a[3:1], 1'h1};
  wire        byt = {xfer_size_hi, xfer_size_lo} == 2'h1;
  initial data_in = 16'h0000;
  always @(posedge sys_clk) begin
    if (addr_strobe_n) begin
      cnt_q <= 2'h0;
      port_ack_hi_n <= 1'h1;
      port_ack_lo_n <= 1'h1;
      data_in <= ~data_in; // released lines never keep old data
    end else if (cnt_q != lat) begin
      cnt_q <= cnt_q + 2'h1;
    end else if (!mute && port_ack_hi_n && port_ack_lo_n) begin
      port_ack_hi_n <= !wide;
      port_ack_lo_n <= wide;
      if (rd_wr_n) begin
        data_in <= wide ? {mem_q[e], mem_q[o]} : {mem_q[a], ~mem_q[a]};
      end else if (!wide) begin
        mem_q[a] <= data_out[15:8];
      end else if (!byt) begin
        mem_q[e] <= data_out[15:8];
        mem_q[o] <= data_out[7:0];
      end else begin
        mem_q[a] <= a[0] ? data_out[7:0] : data_out[15:8];
      end
    end
  end
endmodule : ext_port_model

// ---- verification/tb_ext_bus_sizer.sv ----
module tb_ext_bus_sizer;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, rst_n = 1'h0, op_valid = 1'h0, mute = 1'h0;
  logic bus_fault_n = 1'h1, halt_n = 1'h1, auto_vector_req_n = 1'h1;
  logic op_ready, xfer_size_hi, xfer_size_lo, addr_strobe_n, rd_wr_n;
  logic data_oe, port_ack_hi_n, port_ack_lo_n, wide = 1'h1;
  logic [1:0]  lat = 2'h0;
  logic [15:0] data_out, data_in;
  logic [23:0] addr_out;
  ebs_pkg::op_req_t  op_req = '0;
  ebs_pkg::op_resp_t op_resp, rsp;
  int num_errors = 0, cmp_count = 0, nstb = 0, cyc_n = 0;
  ext_bus_sizer  u_ext_bus_sizer (.*);
  ext_port_model u_ext_port_model (.*);
  // ----------
  // clock, strobe count, hang guard
  // ----------
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if ($fell(addr_strobe_n)) nstb <= nstb + 1;
    if (cyc_n == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // k is {write, int_ack}; request held until taken
  task automatic op(input logic [1:0] k, sz, input logic [23:0] ad,
                    input logic [31:0] wd);
    int i = 0;
    @(posedge sys_clk);
    op_valid <= 1'h1;
    op_req <= '{k[1], k[0], sz, ad, wd};
    do @(negedge sys_clk); while (op_ready !== 1'h1 && ++i < 300);
    @(posedge sys_clk);
    op_valid <= 1'h0;
    do begin
      @(negedge sys_clk);
      rsp = op_resp;
    end while (rsp[36:33] === 4'h0 && ++i < 300);
  endtask : op
  task automatic t_rw(input logic wd);
    int n;
    wide <= wd;
    lat <= wd ? 2'h0 : 2'h3;
    op(2'h2, 2'h0, 24'h8, 32'h1122_3344);
    n = nstb;
    op(2'h0, 2'h0, 24'h8, 32'h0);
    chk(rsp.rdata, 32'h1122_3344);
    chk(nstb - n, wd ? 2 : 4);
  endtask : t_rw
  task automatic t_lanes();
    wide <= 1'h1;
    op(2'h2, 2'h1, 24'h4, 32'h5a);
    op(2'h2, 2'h1, 24'h5, 32'ha5);
    op(2'h0, 2'h2, 24'h4, 32'h0);
    chk(rsp.rdata[15:0], 16'h5aa5);
    wide <= 1'h0;
    op(2'h0, 2'h1, 24'h5, 32'h0);
    chk(rsp.rdata[7:0], 8'ha5);
  endtask : t_lanes
  task automatic t_misal();
    int n = nstb;
    op(2'h0, 2'h2, 24'h7, 32'h0);
    chk(rsp.misaligned, 1'h1);
    chk(nstb - n, 0);
  endtask : t_misal
  task automatic t_err(input logic h);
    @(posedge sys_clk);
    mute <= 1'h1;
    bus_fault_n <= 1'h0;
    halt_n <= h;
    op(2'h0, 2'h2, 24'h2, 32'h0);
    chk(rsp.fault, 1'h1);
    chk(rsp.fault_halt, !h);
    @(posedge sys_clk);
    bus_fault_n <= 1'h1;
    halt_n <= 1'h1;
  endtask : t_err
  task automatic t_auto_vector_req_n();
    @(posedge sys_clk);
    auto_vector_req_n <= 1'h0;
    op(2'h1, 2'h1, 24'h3, 32'h0);
    chk(rsp.auto_vec, 1'h1);
    @(posedge sys_clk);
    auto_vector_req_n <= 1'h1;
    op(2'h0, 2'h1, 24'h3, 32'h0);
    chk(rsp.fault, 1'h1);
    mute <= 1'h0;
  endtask : t_auto_vector_req_n
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_rw(1'h1);
    t_rw(1'h0);
    t_lanes();
    t_misal();
    t_err(1'h1);
    t_err(1'h0);
    t_auto_vector_req_n();
    summarize();
  end
endmodule : tb_ext_bus_sizer
